// ==== hdl/pfss_pkg.sv ====
// Constants, types and register map for the feedback select and standby block
// Behaviour
// RULE1 - Feedback selector takes 0 to 5, resets to 0
// RULE2 - Selector 0 gives analog input 2, selector 1 gives analog input 1
// RULE3 - Selector 2 gives motor current as percent of rated current
// RULE4 - Selector 3 gives DC bus, 0 to 1000 V as 0 to 100 percent
// RULE5 - Selector 4 gives input 1 minus input 2, negatives clamped to zero
// RULE6 - Selector 5 gives the larger of the two analog inputs
// RULE7 - Input 2 format offers 0-10 V (default) and 0-20 mA
// RULE8 - 4-20 mA trip format trips with loss fault below 3 mA
// RULE9 - 4-20 mA fallback format runs preset speed 1 below 3 mA
// RULE10 - Inverted 20-4 mA formats with the same trip and fallback variants
// RULE11 - Thermistor trips at 3 kohm, resets at 1 kohm, needs input 3 trip
// RULE12 - Nonzero standby time enables standby after that long at minimum speed
// RULE13 - In process mode 5 or 6, wake only when error exceeds wake level
// RULE14 - Relay comparison has 0 to 100 percent hysteresis, default 0
// RULE15 - Feedback and thresholds are evaluated once per sample strobe; relay, wake and thermistor reset levels are checked every clock
`default_nettype none
package pfss_pkg;
   // Percent values are in tenths of a percent, 1000 is full scale
   localparam int PW = 16;
   localparam int AW = 6;
   localparam logic [PW-1:0] PCT_FULL = 16'h03E8;
   localparam logic [PW-1:0] PCT_SAT = 16'h07D0;
   // Register byte addresses
   localparam logic [AW-1:0] OFS_CFG = 6'h00;
   localparam logic [AW-1:0] OFS_RATED = 6'h04;
   localparam logic [AW-1:0] OFS_STBY = 6'h08;
   localparam logic [AW-1:0] OFS_WAKE = 6'h0C;
   localparam logic [AW-1:0] OFS_RTHR = 6'h10;
   localparam logic [AW-1:0] OFS_RHYS = 6'h14;
   localparam logic [AW-1:0] OFS_STAT = 6'h18;
   localparam logic [AW-1:0] OFS_ISTAT = 6'h1C;
   localparam logic [AW-1:0] OFS_IMASK = 6'h20;
   localparam logic [AW-1:0] OFS_CMD = 6'h24;
   // Field positions
   localparam int CFG_SEL_LSB = 0;
   localparam int CFG_FMT_LSB = 4;
   localparam int CFG_DI3_BIT = 8;
   localparam int CFG_MODE_LSB = 12;
   localparam int CMD_FRST_BIT = 0;
   localparam int NEV = 5;
   localparam int EV_LOSS = 0;
   localparam int EV_FALLBK = 1;
   localparam int EV_THERM = 2;
   localparam int EV_STBY = 3;
   localparam int EV_WAKE = 4;
   // Reset values, limits and process mode codes
   localparam logic [2:0] SEL_MAX = 3'h5;
   localparam logic [2:0] SEL_RST = 3'h0;
   localparam logic [3:0] MODE_RST = 4'h0;
   localparam logic [3:0] MODE_PI_A = 4'h5;
   localparam logic [3:0] MODE_PI_B = 4'h6;
   localparam logic [PW-1:0] RATED_RST = 16'h0064;
   localparam logic [7:0] STBY_RST = 8'h00;
   localparam logic [7:0] STBY_MAX = 8'hFA;
   localparam logic [PW-1:0] WAKE_RST = 16'h0032;
   localparam logic [PW-1:0] RTHR_RST = 16'h0000;
   localparam logic [PW-1:0] RHYS_RST = 16'h0000;
   // Analog input 2 thresholds, microamps and ohms
   localparam logic [PW-1:0] UA_LOSS = 16'h0BB8;
   localparam logic [PW-1:0] UA_LIVE0 = 16'h0FA0;
   localparam logic [PW-1:0] OHM_TRIP = 16'h0BB8;
   localparam logic [PW-1:0] OHM_RESET = 16'h03E8;
   // Standby time step and clock, and the read data reset value
   localparam int STEP_MS = 100;
   localparam int CLK_KHZ = 100000;
   localparam int STEP_CYC = STEP_MS * CLK_KHZ;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;
   typedef enum logic [2:0] {
      PFSS_V10, PFSS_A20, PFSS_T420, PFSS_R420, PFSS_T204, PFSS_R204,
      PFSS_THERM
   } pfss_fmt_t;
   // One measurement set, all on ref_clk
   typedef struct packed {
      logic [PW-1:0] ain1;
      logic [PW-1:0] ain2_raw;
      logic [PW-1:0] mot_cur;
      logic [PW-1:0] dc_volts;
      logic [PW-1:0] therm_ohm;
   } pfss_meas_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [AW-1:0] addr;
      logic [31:0] wdata;
   } pfss_bus_t;
endpackage
`default_nettype wire

// ==== hdl/pfss_top.sv ====
// Feedback source select, input 2 supervision, standby and relay hysteresis
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module pfss_top import pfss_pkg::*; #(
   parameter int STEP_CYCLES = STEP_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Register port
   input wire pfss_bus_t bus,
   output logic [31:0] rdata,
   output logic irq,
   // Measurements, one set per strobe
   input wire logic sample_stb,
   input wire pfss_meas_t meas,
   // Drive state
   input wire logic at_min_speed,
   input wire logic [PW-1:0] setpoint,
   input wire logic [PW-1:0] relay_value,
   // Results
   output logic [PW-1:0] feedback,
   output logic loss_trip,
   output logic fallback_preset1,
   output logic therm_trip,
   output logic standby,
   output logic relay_on
);

   function automatic logic [PW-1:0] sat(input logic [31:0] v);
      sat = (v > 32'(PCT_SAT)) ? PCT_SAT : v[PW-1:0];
   endfunction

   function automatic logic is_reg(input logic [AW-1:0] a,
                                   input logic [AW-1:0] o);
      is_reg = (a == o);
   endfunction

   // Current formats whose signal loss trips the drive
   function automatic logic is_trip_fmt(input pfss_fmt_t f);
      is_trip_fmt = (f == PFSS_T420) || (f == PFSS_T204);
   endfunction

   // Current formats that fall back to preset speed 1 instead
   function automatic logic is_fbk_fmt(input pfss_fmt_t f);
      is_fbk_fmt = (f == PFSS_R420) || (f == PFSS_R204);
   endfunction

   logic [2:0] sel_q;
   pfss_fmt_t fmt_q;
   logic di3_trip_q;
   logic [3:0] mode_q;
   logic [PW-1:0] rated_q, wake_q, rthr_q, rhys_q;
   logic [7:0] stby_q;
   logic [NEV-1:0] ist_q, imask_q, ev;
   logic [PW-1:0] fb_q, fb_d, ain2_pm;
   logic loss_q, fbk_q, therm_q, stby_on_q, relay_q, irq_q;
   logic [31:0] rdata_q;
   logic sig_lost, wr_cfg, fault_rst;
   logic [31:0] cur_pm;
   logic [31:0] tick_q;
   logic [7:0] steps_q;
   logic pi_mode, wake_now, enter_now;
   logic [PW:0] err;
   logic [PW:0] off_lvl;
   logic [PW-1:0] ain1_pm;
   logic [NEV-1:0] ist_d, imask_d;
   logic loss_hit, fbk_hit, therm_hit;
   logic rd_istat, relay_off;

   assign wr_cfg = bus.wr && is_reg(bus.addr, OFS_CFG);
   assign fault_rst = bus.wr && is_reg(bus.addr, OFS_CMD) &&
                      bus.wdata[CMD_FRST_BIT];

   // Configuration writes; out of range codes keep the old setting
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sel_q <= SEL_RST; // [RULE1]
         fmt_q <= PFSS_V10; // [RULE7]
         di3_trip_q <= 1'b0;
         mode_q <= MODE_RST;
      end else if (wr_cfg) begin
         if (bus.wdata[CFG_SEL_LSB+:3] <= SEL_MAX) begin
            sel_q <= bus.wdata[CFG_SEL_LSB+:3]; // [RULE1]
         end
         if (bus.wdata[CFG_FMT_LSB+:3] <= 3'(PFSS_THERM)) begin
            fmt_q <= pfss_fmt_t'(bus.wdata[CFG_FMT_LSB+:3]); // [RULE7]
         end
         di3_trip_q <= bus.wdata[CFG_DI3_BIT];
         mode_q <= bus.wdata[CFG_MODE_LSB+:4];
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rated_q <= RATED_RST;
         stby_q <= STBY_RST;
         wake_q <= WAKE_RST;
         rthr_q <= RTHR_RST;
         rhys_q <= RHYS_RST;
      end else if (bus.wr) begin
         if (is_reg(bus.addr, OFS_RATED)) begin
            rated_q <= bus.wdata[PW-1:0];
         end
         if (is_reg(bus.addr, OFS_STBY) && bus.wdata[7:0] <= STBY_MAX) begin
            stby_q <= bus.wdata[7:0]; // [RULE12]
         end
         if (is_reg(bus.addr, OFS_WAKE) && bus.wdata[PW-1:0] <= PCT_FULL) begin
            wake_q <= bus.wdata[PW-1:0]; // [RULE13]
         end
         if (is_reg(bus.addr, OFS_RTHR)) begin
            rthr_q <= bus.wdata[PW-1:0];
         end
         if (is_reg(bus.addr, OFS_RHYS) && bus.wdata[PW-1:0] <= PCT_FULL) begin
            rhys_q <= bus.wdata[PW-1:0]; // [RULE14]
         end
      end
   end

   // Input 2 level in tenths of percent; raw is mV or uA per format
   always_comb begin
      ain2_pm = '0;
      sig_lost = 1'b0;
      unique case (fmt_q)
         PFSS_V10: ain2_pm = sat(32'(meas.ain2_raw) / 32'd10); // [RULE7]
         PFSS_A20: ain2_pm = sat(32'(meas.ain2_raw) / 32'd20); // [RULE7]
         PFSS_T420, PFSS_R420, PFSS_T204, PFSS_R204: begin
            sig_lost = meas.ain2_raw < UA_LOSS; // [RULE8] [RULE9] [RULE10]
            if (meas.ain2_raw > UA_LIVE0) begin
               ain2_pm = sat((32'(meas.ain2_raw) - 32'(UA_LIVE0)) / 32'd16);
            end
            if (fmt_q == PFSS_T204 || fmt_q == PFSS_R204) begin
               ain2_pm = (ain2_pm > PCT_FULL) ? '0 :
                         PCT_FULL - ain2_pm; // [RULE10]
            end
         end
         PFSS_THERM: ain2_pm = '0;
      endcase
   end

   // Hardware divider; a zero rated current gives zero feedback
   assign cur_pm = (rated_q == '0) ? 32'd0 :
                   (32'(meas.mot_cur) * 32'd1000) / 32'(rated_q);
   // Input 1 clamped like every other source
   assign ain1_pm = sat(32'(meas.ain1));

   always_comb begin
      fb_d = '0;
      unique case (sel_q)
         3'h0: fb_d = ain2_pm; // [RULE2]
         3'h1: fb_d = ain1_pm; // [RULE2]
         3'h2: fb_d = sat(cur_pm); // [RULE3]
         3'h3: fb_d = sat(32'(meas.dc_volts)); // [RULE4]
         3'h4: fb_d = (ain1_pm > ain2_pm) ?
                      ain1_pm - ain2_pm : '0; // [RULE5]
         3'h5: fb_d = (ain1_pm > ain2_pm) ? ain1_pm : ain2_pm; // [RULE6]
         default: fb_d = '0;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fb_q <= '0;
      end else if (sample_stb) begin
         fb_q <= fb_d; // [RULE15]
      end
   end

   // Qualified sample events, shared by the latches and the status bits
   assign loss_hit = sample_stb && sig_lost && is_trip_fmt(fmt_q);
   assign fbk_hit = sample_stb && sig_lost && is_fbk_fmt(fmt_q);
   assign therm_hit = sample_stb && fmt_q == PFSS_THERM && di3_trip_q &&
                      meas.therm_ohm >= OHM_TRIP;

   // Trip latches until a fault reset; a new loss in that cycle wins
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         loss_q <= 1'b0;
      end else if (loss_hit) begin
         loss_q <= 1'b1; // [RULE8] [RULE10] [RULE15]
      end else if (fault_rst) begin
         loss_q <= 1'b0;
      end
   end

   // Fallback follows the signal, no latch, so speed returns on recovery
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fbk_q <= 1'b0;
      end else if (sample_stb) begin
         fbk_q <= sig_lost && is_fbk_fmt(fmt_q); // [RULE9] [RULE10]
      end
   end

   // Thermistor trip; the reset needs the resistance back down
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         therm_q <= 1'b0;
      end else if (therm_hit) begin
         therm_q <= 1'b1; // [RULE11] [RULE15]
      end else if (fault_rst && meas.therm_ohm <= OHM_RESET) begin
         therm_q <= 1'b0; // [RULE11]
      end
   end

   // Standby entry after stby_q steps of 100 ms at minimum speed
   assign pi_mode = (mode_q == MODE_PI_A) || (mode_q == MODE_PI_B);
   assign err = {1'b0, setpoint} - {1'b0, fb_q};
   assign enter_now = !stby_on_q && at_min_speed && stby_q != '0 &&
                      steps_q == stby_q;
   always_comb begin
      if (stby_q == '0) begin
         wake_now = stby_on_q; // [RULE12]
      end else if (pi_mode) begin
         wake_now = stby_on_q && !err[PW] &&
                    err[PW-1:0] > wake_q; // [RULE13]
      end else begin
         wake_now = stby_on_q && !at_min_speed;
      end
   end

   // Counting restarts whenever the drive leaves minimum speed
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tick_q <= '0;
         steps_q <= '0;
      end else if (!at_min_speed || stby_on_q || stby_q == '0) begin
         tick_q <= '0;
         steps_q <= '0;
      end else if (tick_q == 32'(STEP_CYCLES - 1)) begin
         tick_q <= '0;
         if (steps_q != stby_q) begin
            steps_q <= steps_q + 8'h01; // [RULE12]
         end
      end else begin
         tick_q <= tick_q + 32'h0000_0001;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         stby_on_q <= 1'b0;
      end else if (enter_now) begin
         stby_on_q <= 1'b1; // [RULE12]
      end else if (wake_now) begin
         stby_on_q <= 1'b0; // [RULE13]
      end
   end

   // Relay on at threshold, off only below threshold minus hysteresis
   assign off_lvl = {1'b0, rthr_q} - {1'b0, rhys_q};
   // Hysteresis above the threshold leaves the relay latched on
   assign relay_off = !off_lvl[PW] && relay_value < off_lvl[PW-1:0];
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         relay_q <= 1'b0;
      end else if (relay_value >= rthr_q) begin
         relay_q <= 1'b1; // [RULE14]
      end else if (relay_off) begin
         relay_q <= 1'b0; // [RULE14]
      end
   end

   // Interrupt events; a read clears, but a same-cycle event is kept
   assign ev[EV_LOSS] = !loss_q && loss_hit;
   assign ev[EV_FALLBK] = !fbk_q && fbk_hit;
   assign ev[EV_THERM] = !therm_q && therm_hit;
   assign ev[EV_STBY] = enter_now;
   assign ev[EV_WAKE] = wake_now && !enter_now;
   assign rd_istat = bus.rd && is_reg(bus.addr, OFS_ISTAT);

   // Next status and mask, so irq follows both with no lag
   always_comb begin
      ist_d = ist_q | ev;
      if (rd_istat) begin
         ist_d = ev;
      end
      imask_d = imask_q;
      if (bus.wr && is_reg(bus.addr, OFS_IMASK)) begin
         imask_d = bus.wdata[NEV-1:0];
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ist_q <= '0;
      end else begin
         ist_q <= ist_d;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         imask_q <= '0;
      end else begin
         imask_q <= imask_d;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(ist_d & imask_d);
      end
   end

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdata_q <= RDATA_RST;
      end else if (!bus.rd) begin
         rdata_q <= RDATA_RST;
      end else begin
         unique case (bus.addr)
            OFS_CFG: rdata_q <= 32'({mode_q, 3'b000, di3_trip_q,
                                     1'b0, 3'(fmt_q), 1'b0, sel_q});
            OFS_RATED: rdata_q <= 32'(rated_q);
            OFS_STBY: rdata_q <= 32'(stby_q);
            OFS_WAKE: rdata_q <= 32'(wake_q);
            OFS_RTHR: rdata_q <= 32'(rthr_q);
            OFS_RHYS: rdata_q <= 32'(rhys_q);
            OFS_STAT: rdata_q <= {11'h000, relay_q, stby_on_q, therm_q,
                                  fbk_q, loss_q, fb_q};
            OFS_ISTAT: rdata_q <= 32'(ist_q);
            OFS_IMASK: rdata_q <= 32'(imask_q);
            default: rdata_q <= RDATA_RST;
         endcase
      end
   end

   assign rdata = rdata_q;
   assign irq = irq_q;
   assign feedback = fb_q;
   assign loss_trip = loss_q;
   assign fallback_preset1 = fbk_q;
   assign therm_trip = therm_q;
   assign standby = stby_on_q;
   assign relay_on = relay_q;

endmodule // pfss_top
`default_nettype wire

// ==== tb/pfss_assertions.sv ====
// Port-level checker for the feedback select and standby block
`timescale 1ns/10ps
`default_nettype none
module pfss_assertions import pfss_pkg::*; (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Register port
   input wire pfss_bus_t bus,
   input wire logic [31:0] rdata,
   // Measurements and drive state
   input wire logic sample_stb,
   input wire pfss_meas_t meas,
   input wire logic at_min_speed,
   // Results
   input wire logic [PW-1:0] feedback,
   input wire logic loss_trip,
   input wire logic fallback_preset1,
   input wire logic therm_trip,
   input wire logic standby
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic frst;
   // Fault reset command seen on the bus this cycle
   assign frst = bus.wr && bus.addr == OFS_CMD && bus.wdata[CMD_FRST_BIT];
   rdata_idle_a: assert property (
      !bus.rd |=> rdata == 32'h0000_0000)
      else $error("read data outside the read slot");
   fb_hold_a: assert property (
      !sample_stb |=> $stable(feedback))
      else $error("feedback moved without a strobe");
   loss_rise_a: assert property (
      $rose(loss_trip) |-> $past(sample_stb) && $past(meas.ain2_raw) < UA_LOSS)
      else $error("loss trip without a low sample");
   fallbk_rise_a: assert property (
      $rose(fallback_preset1) |->
      $past(sample_stb) && $past(meas.ain2_raw) < UA_LOSS)
      else $error("fallback without a low sample");
   therm_rise_a: assert property (
      $rose(therm_trip) |->
      $past(sample_stb) && $past(meas.therm_ohm) >= OHM_TRIP)
      else $error("thermistor trip below trip level");
   loss_latch_a: assert property (
      loss_trip && !frst |=> loss_trip)
      else $error("loss trip dropped without reset");
   therm_latch_a: assert property (
      therm_trip && !frst |=> therm_trip)
      else $error("thermistor trip dropped without reset");
   stby_rise_a: assert property (
      $rose(standby) |-> $past(at_min_speed, 1) && $past(at_min_speed, 2))
      else $error("standby entered off minimum speed");
endmodule // pfss_assertions
bind pfss_top pfss_assertions u_chk (.ref_clk, .rst, .bus, .rdata,
   .sample_stb, .meas, .at_min_speed, .feedback, .loss_trip,
   .fallback_preset1, .therm_trip, .standby);
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the feedback select and standby block
`timescale 1ns/10ps
`default_nettype none
module tb_top import pfss_pkg::*; ;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   pfss_bus_t bus = '0;
   logic sample_stb = 1'b0;
   pfss_meas_t meas = '0;
   logic at_min_speed = 1'b0;
   logic [PW-1:0] setpoint = '0;
   logic [PW-1:0] relay_value = '0;
   logic [31:0] rdata;
   logic [PW-1:0] feedback;
   logic irq, loss_trip, fallback_preset1, therm_trip, standby, relay_on;
   int bad_count = 0;
   int total_checks = 0;
   always #5 ref_clk = ~ref_clk;
   // Short standby step keeps the run brief
   pfss_top #(.STEP_CYCLES(10)) dut (.ref_clk, .rst, .bus, .rdata, .irq,
      .sample_stb, .meas, .at_min_speed, .setpoint, .relay_value,
      .feedback, .loss_trip, .fallback_preset1, .therm_trip, .standby,
      .relay_on);
   function automatic logic [31:0] cf(logic [2:0] s, logic [2:0] f,
         logic d, logic [3:0] m);
      return {16'h0000, m, 3'h0, d, 1'b0, f, 1'b0, s};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      bus <= '{1'b1, 1'b0, a, d};
      @(posedge ref_clk);
      bus <= '0;
   endtask
   task automatic rdx(input logic [AW-1:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      bus <= '{1'b0, 1'b1, a, 32'h0000_0000};
      @(posedge ref_clk);
      bus <= '0;
      #1 chk(rdata, e);
   endtask
   task automatic smp(input logic [PW-1:0] a1, a2, cu, v, oh);
      @(posedge ref_clk);
      meas <= '{a1, a2, cu, v, oh};
      sample_stb <= 1'b1;
      @(posedge ref_clk);
      sample_stb <= 1'b0;
      #1;
   endtask
   task automatic t_reset();
      rdx(OFS_CFG, 32'h0000_0000);
      rdx(OFS_RATED, 32'h0000_0064);
      rdx(OFS_WAKE, 32'h0000_0032);
      rdx(OFS_STBY, 32'h0000_0000);
      rdx(OFS_RHYS, 32'h0000_0000);
      rdx(6'h3C, 32'h0000_0000);
   endtask
   task automatic t_select();
      logic [PW-1:0] e [6] = '{16'h012C, 16'h0258, 16'h01F4, 16'h0190,
         16'h012C, 16'h0258};
      for (int s = 0; s < 6; s++) begin
         wr(OFS_CFG, cf(3'(s), 3'h0, 1'b0, 4'h0));
         smp(16'h0258, 16'h0BB8, 16'h0032, 16'h0190, 16'h0000);
         chk(32'(feedback), 32'(e[s]));
      end
      smp(16'h00C8, 16'h0BB8, 16'h0000, 16'h0000, 16'h0000);
      chk(32'(feedback), 32'h0000_012C);
      wr(OFS_CFG, cf(3'h4, 3'h0, 1'b0, 4'h0));
      smp(16'h00C8, 16'h0BB8, 16'h0000, 16'h0000, 16'h0000);
      chk(32'(feedback), 32'h0000_0000);
      wr(OFS_CFG, cf(3'h7, 3'h0, 1'b0, 4'h0));
      rdx(OFS_CFG, 32'h0000_0004);
   endtask
   task automatic t_format();
      logic [PW-1:0] lv [4] = '{16'h00FA, 16'h00FA, 16'h02EE, 16'h02EE};
      wr(OFS_CFG, cf(3'h0, 3'h1, 1'b0, 4'h0));
      smp(16'h0000, 16'h2710, 16'h0000, 16'h0000, 16'h0000);
      chk(32'(feedback), 32'h0000_01F4);
      for (int f = 2; f < 6; f++) begin
         wr(OFS_CFG, cf(3'h0, 3'(f), 1'b0, 4'h0));
         smp(16'h0000, 16'h1F40, 16'h0000, 16'h0000, 16'h0000);
         chk(32'(feedback), 32'(lv[f-2]));
         smp(16'h0000, 16'h0BB8, 16'h0000, 16'h0000, 16'h0000);
         chk(32'(loss_trip | fallback_preset1), 32'h0);
         smp(16'h0000, 16'h0BB7, 16'h0000, 16'h0000, 16'h0000);
         chk(32'(loss_trip), 32'(f % 2 == 0));
         chk(32'(fallback_preset1), 32'(f % 2));
         smp(16'h0000, 16'h1F40, 16'h0000, 16'h0000, 16'h0000);
         wr(OFS_CMD, 32'h0000_0001);
         cyc(1);
         chk(32'(loss_trip | fallback_preset1), 32'h0);
      end
   endtask
   task automatic t_irq();
      chk(32'(irq), 32'h0);
      rdx(OFS_ISTAT, 32'h0000_0003);
      rdx(OFS_ISTAT, 32'h0000_0000);
      wr(OFS_IMASK, 32'h0000_0001);
      wr(OFS_CFG, cf(3'h0, 3'h2, 1'b0, 4'h0));
      smp(16'h0000, 16'h0BB7, 16'h0000, 16'h0000, 16'h0000);
      cyc(2);
      chk(32'(irq), 32'h1);
      rdx(OFS_ISTAT, 32'h0000_0001);
      cyc(2);
      chk(32'(irq), 32'h0);
      smp(16'h0000, 16'h1F40, 16'h0000, 16'h0000, 16'h0000);
      wr(OFS_CMD, 32'h0000_0001);
   endtask
   task automatic t_therm();
      wr(OFS_CFG, cf(3'h0, 3'h6, 1'b1, 4'h0));
      smp(16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0BB7);
      chk(32'(therm_trip), 32'h0);
      smp(16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0BB8);
      chk(32'(therm_trip), 32'h1);
      smp(16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h07D0);
      wr(OFS_CMD, 32'h0000_0001);
      cyc(1);
      chk(32'(therm_trip), 32'h1);
      smp(16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h03E8);
      wr(OFS_CMD, 32'h0000_0001);
      cyc(1);
      chk(32'(therm_trip), 32'h0);
      wr(OFS_CFG, cf(3'h0, 3'h6, 1'b0, 4'h0));
      smp(16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h1388);
      chk(32'(therm_trip), 32'h0);
      rdx(OFS_ISTAT, 32'h0000_0004);
   endtask
   task automatic t_standby();
      wr(OFS_CFG, cf(3'h1, 3'h0, 1'b0, 4'h5));
      setpoint <= 16'h01F4;
      smp(16'h01F4, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
      wr(OFS_STBY, 32'h0000_0003);
      at_min_speed <= 1'b1;
      cyc(27);
      chk(32'(standby), 32'h0);
      for (int i = 0; i < 10 && standby !== 1'b1; i++) cyc(1);
      chk(32'(standby), 32'h1);
      @(posedge ref_clk);
      at_min_speed <= 1'b0;
      setpoint <= 16'h0226;
      cyc(5);
      chk(32'(standby), 32'h1);
      @(posedge ref_clk);
      setpoint <= 16'h0227;
      for (int i = 0; i < 5 && standby !== 1'b0; i++) cyc(1);
      chk(32'(standby), 32'h0);
      rdx(OFS_ISTAT, 32'h0000_0018);
   endtask
   task automatic t_relay();
      logic [PW-1:0] v [6] = '{16'h018F, 16'h01F3, 16'h01F4, 16'h01C2,
         16'h0190, 16'h018F};
      logic e [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
      wr(OFS_RTHR, 32'h0000_01F4);
      wr(OFS_RHYS, 32'h0000_0064);
      for (int i = 0; i < 6; i++) begin
         @(posedge ref_clk);
         relay_value <= v[i];
         cyc(2);
         chk(32'(relay_on), 32'(e[i]));
      end
   endtask
   task automatic summarize();
      $display("checks=%0d errors=%0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset();
      t_select();
      t_format();
      t_irq();
      t_therm();
      t_standby();
      t_relay();
      summarize();
   end
   // Watchdog against a hung sequence
   initial begin
      #200000;
      bad_count++;
      summarize();
   end
endmodule // tb_top
`default_nettype wire
